/* lcb_config_regs.sv */
// compensation and bias configuration registers behind block transactions
//
// Operation
// [R1] current integrating cap code, bits 25:24,39:38
// [R2] current filter cap code in bits 37:33
// [R3] bit 32 doubles current integrating cap
// [R4] current gain resistor code in bits 31:26
// [R5] voltage integrating cap code, bits 9:8,23:22
// [R6] voltage filter cap code in bits 21:17
// [R7] voltage gain resistor code in bits 15:10
// [R8] host writes zero to reserved compensation bits
// [R9] voltage transconductance exponent in bits 5:4
// [R10] current transconductance exponent in bits 1:0
// [R11] writes while converting wait for update path
// [R12] writes while stopped reach loop directly
// [R13] store, clear override, restore or cycle supply
// [R14] bias register uses block transfers, one byte
// [R15] bias transfer and apply within 1 ms
// [R16] bias codes 3h to Ah valid only
// [R17] bias bits 3:0 read as zero
// [R18] host avoids lowest bias without external supply
// [R19] compensation is 40-bit block at B1h
// [R20] invalid bias code rejected, flagged, kept
`timescale 1ns/100ps
module lcb_config_regs #(
  parameter int MAX_TXN_CYC = lcb_pkg::TXN_MAX_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic txn_start,
  input wire logic [7:0] txn_cmd,
  input wire logic txn_read,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  input wire logic txn_stop,
  input wire logic conv_enable,
  input wire logic store_all,
  input wire logic restore_all,
  input wire logic strap_override_mask,
  input wire logic analog_supply_input,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic txn_done,
  output logic nack_data,
  output logic nack_cmd,
  output logic txn_timeout,
  output logic comp_pending,
  output logic [3:0] cur_integ_cap_code,
  output logic [4:0] cur_filter_cap_code,
  output logic cur_integ_cap_doubler,
  output logic [5:0] cur_gain_res_code,
  output logic [3:0] volt_integ_cap_code,
  output logic [4:0] volt_filter_cap_code,
  output logic [5:0] volt_gain_res_code,
  output logic [1:0] volt_transcond_exp,
  output logic [1:0] cur_transcond_exp,
  output logic [3:0] bias_voltage_code,
  output logic bias_apply
);
  localparam int TW = $clog2(MAX_TXN_CYC + 1);
  localparam int XB = 5;

  typedef struct packed {
    logic [39:0] pm_comp;
    logic [3:0] pm_bias;
    logic [39:0] nvm_comp;
    logic [3:0] nvm_bias;
    logic [39:0] act_comp;
    logic [3:0] act_bias;
    logic analog_supply_input_s1;
    logic analog_supply_input_s2;
    logic analog_supply_input_prev;
    logic in_txn;
    logic is_read;
    logic sel_bias;
    logic [TW-1:0] timer;
    logic bias_apply;
    logic txn_done;
    logic nack_data;
    logic nack_cmd;
    logic txn_timeout;
  } lcb_regs_t;

  lcb_regs_t s_r;
  lcb_regs_t s_nxt;

  logic hit_comp;
  logic hit_bias;
  logic start_hit;
  logic blk_wr;
  logic blk_rd;
  logic blk_load;
  logic [8*XB-1:0] load_data;
  logic [7:0] load_count;
  logic [8*XB-1:0] cap_data;
  logic [7:0] cap_count;
  logic [7:0] cap_bytes;
  logic [3:0] wr_code;
  logic comp_ok;
  logic bias_len_ok;
  logic bias_code_ok;
  logic supply_cycled;

  // command decode for the two blocks served here
  assign hit_comp = (txn_cmd == lcb_pkg::CMD_COMP); // [R19]
  assign hit_bias = (txn_cmd == lcb_pkg::CMD_BIAS); // [R14]
  assign start_hit = txn_start && !s_r.in_txn && (hit_comp || hit_bias);
  assign blk_wr = wr_valid && s_r.in_txn && !s_r.is_read;
  assign blk_rd = rd_req && s_r.in_txn && s_r.is_read;
  assign blk_load = start_hit && txn_read;

  // read image: byte count first, then data low byte first
  always_comb begin
    if (hit_bias) begin
      load_count = lcb_pkg::BIAS_BYTES; // [R14]
      load_data = {32'h0000_0000, s_r.pm_bias, lcb_pkg::BIAS_RSVD}; // [R17]
    end else begin
      load_count = lcb_pkg::COMP_BYTES; // [R19]
      load_data = s_r.pm_comp;
    end
  end

  lcb_blk_xfer #(
    .BYTES(XB)
  ) u_xfer (
    .clock(clock),
    .resetn(resetn),
    .clear(start_hit),
    .wr_valid(blk_wr),
    .wr_data(wr_data),
    .load(blk_load),
    .load_data(load_data),
    .load_count(load_count),
    .rd_req(blk_rd),
    .cap_data(cap_data),
    .cap_count(cap_count),
    .cap_bytes(cap_bytes),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
  );

  // write checks on the collected block
  assign comp_ok = (cap_count == lcb_pkg::COMP_BYTES) &&
                   (cap_bytes == lcb_pkg::COMP_BYTES); // [R19]
  assign bias_len_ok = (cap_count == lcb_pkg::BIAS_BYTES) &&
                       (cap_bytes == lcb_pkg::BIAS_BYTES); // [R14]
  assign wr_code = cap_data[lcb_pkg::BIAS_CODE_LSB +: 4];
  assign bias_code_ok = (wr_code >= lcb_pkg::BIAS_CODE_MIN) &&
                        (wr_code <= lcb_pkg::BIAS_CODE_MAX); // [R16]

  // supply brought back above lockout
  assign supply_cycled = s_r.analog_supply_input_s2 && !s_r.analog_supply_input_prev; // [R13]

  always_comb begin
    s_nxt = s_r;
    s_nxt.bias_apply = 1'b0;
    s_nxt.txn_done = 1'b0;
    s_nxt.nack_data = 1'b0;
    s_nxt.nack_cmd = 1'b0;
    s_nxt.txn_timeout = 1'b0;
    s_nxt.analog_supply_input_s1 = analog_supply_input;
    s_nxt.analog_supply_input_s2 = s_r.analog_supply_input_s1;
    s_nxt.analog_supply_input_prev = s_r.analog_supply_input_s2;

    // transaction framing
    if (!s_r.in_txn) begin
      if (start_hit) begin
        s_nxt.in_txn = 1'b1;
        s_nxt.is_read = txn_read;
        s_nxt.sel_bias = hit_bias;
        s_nxt.timer = '0;
      end else if (txn_start && !s_r.in_txn) begin
        s_nxt.nack_cmd = 1'b1;
      end
    end else if (txn_stop) begin
      s_nxt.in_txn = 1'b0;
      s_nxt.txn_done = 1'b1;
      if (!s_r.is_read) begin
        if (s_r.sel_bias) begin
          if (bias_len_ok && bias_code_ok) begin
            s_nxt.pm_bias = wr_code;
            // applied on the fly, next edge
            s_nxt.act_bias = wr_code; // [R15]
            s_nxt.bias_apply = 1'b1; // [R15]
          end else begin
            // previous setting stays
            s_nxt.nack_data = 1'b1; // [R20]
          end
        end else if (comp_ok) begin
          s_nxt.pm_comp = cap_data;
          if (!conv_enable) begin
            s_nxt.act_comp = cap_data; // [R12]
          end
          // while converting only the bus copy changes [R11]
        end else begin
          s_nxt.nack_data = 1'b1;
        end
      end
    end else if (s_r.timer == TW'(MAX_TXN_CYC - 1)) begin
      // stuck transfer abandoned, nothing is written
      s_nxt.in_txn = 1'b0;
      s_nxt.txn_timeout = 1'b1; // [R15]
    end else begin
      s_nxt.timer = s_r.timer + TW'(1);
    end

    // save bus copies to the nonvolatile image
    if (store_all) begin
      s_nxt.nvm_comp = s_r.pm_comp; // [R13]
      s_nxt.nvm_bias = s_r.pm_bias;
    end

    // reload from the image; loop takes it unless strap overrides
    if (restore_all || supply_cycled) begin
      s_nxt.pm_comp = s_r.nvm_comp;
      s_nxt.pm_bias = s_r.nvm_bias;
      s_nxt.act_bias = s_r.nvm_bias;
      s_nxt.bias_apply = 1'b1;
      if (!strap_override_mask) begin
        s_nxt.act_comp = s_r.nvm_comp; // [R13]
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.pm_comp <= lcb_pkg::COMP_RST;
      s_r.nvm_comp <= lcb_pkg::COMP_RST;
      s_r.act_comp <= lcb_pkg::COMP_RST;
      s_r.pm_bias <= lcb_pkg::BIAS_RST;
      s_r.nvm_bias <= lcb_pkg::BIAS_RST;
      s_r.act_bias <= lcb_pkg::BIAS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // status
  assign txn_done = s_r.txn_done;
  assign nack_data = s_r.nack_data;
  assign nack_cmd = s_r.nack_cmd;
  assign txn_timeout = s_r.txn_timeout;
  assign bias_apply = s_r.bias_apply;
  assign comp_pending = (s_r.pm_comp != s_r.act_comp); // [R11]

  // loop settings in force
  assign cur_integ_cap_code =
    {s_r.act_comp[lcb_pkg::CZI_HI_LSB +: 2],
     s_r.act_comp[lcb_pkg::CZI_LO_LSB +: 2]}; // [R1]
  assign cur_filter_cap_code = s_r.act_comp[lcb_pkg::CPI_LSB +: 5]; // [R2]
  assign cur_integ_cap_doubler = s_r.act_comp[lcb_pkg::CZI_MUL_BIT]; // [R3]
  assign cur_gain_res_code = s_r.act_comp[lcb_pkg::RVI_LSB +: 6]; // [R4]
  assign volt_integ_cap_code =
    {s_r.act_comp[lcb_pkg::CZV_HI_LSB +: 2],
     s_r.act_comp[lcb_pkg::CZV_LO_LSB +: 2]}; // [R5]
  assign volt_filter_cap_code = s_r.act_comp[lcb_pkg::CPV_LSB +: 5]; // [R6]
  assign volt_gain_res_code = s_r.act_comp[lcb_pkg::RVV_LSB +: 6]; // [R7]
  assign volt_transcond_exp = s_r.act_comp[lcb_pkg::GMV_LSB +: 2]; // [R9]
  assign cur_transcond_exp = s_r.act_comp[lcb_pkg::GMI_LSB +: 2]; // [R10]
  assign bias_voltage_code = s_r.act_bias; // [R16]
endmodule

/* lcb_pkg.sv */
// constants for the loop compensation and bias configuration registers
package lcb_pkg;
  // command codes
  localparam logic [7:0] CMD_COMP = 8'hb1;
  localparam logic [7:0] CMD_BIAS = 8'hb5;
  localparam logic [7:0] CMD_STORE_ALL = 8'h15;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
  localparam logic [7:0] CMD_OVERRIDE = 8'hee;
  // block byte counts
  localparam logic [7:0] COMP_BYTES = 8'h05;
  localparam logic [7:0] BIAS_BYTES = 8'h01;
  localparam int COMP_WIDTH = 40;
  // compensation field positions
  localparam int CZI_HI_LSB = 24;
  localparam int CZI_LO_LSB = 38;
  localparam int CPI_LSB = 33;
  localparam int CZI_MUL_BIT = 32;
  localparam int RVI_LSB = 26;
  localparam int CZV_HI_LSB = 8;
  localparam int CZV_LO_LSB = 22;
  localparam int CPV_LSB = 17;
  localparam int RVV_LSB = 10;
  localparam int GMV_LSB = 4;
  localparam int GMI_LSB = 0;
  // bias register fields
  localparam int BIAS_CODE_LSB = 4;
  localparam logic [3:0] BIAS_RSVD = 4'h0;
  localparam logic [3:0] BIAS_CODE_MIN = 4'h3;
  localparam logic [3:0] BIAS_CODE_MAX = 4'ha;
  // reset images of the nonvolatile copy
  localparam logic [39:0] COMP_RST = 40'h00_0000_0000;
  localparam logic [3:0] BIAS_RST = 4'h8;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam real TXN_MAX_MS = 1.0;
  localparam real ACTION_MAX_MS = 1.0;
  localparam int TXN_MAX_CYC = int'(TXN_MAX_MS * 1000000.0) / CLK_PERIOD_NS;
  localparam int ACTION_MAX_CYC =
    int'(ACTION_MAX_MS * 1000000.0) / CLK_PERIOD_NS;
endpackage

/* lcb_blk_xfer.sv */
// byte collector and byte server for one block transaction
`timescale 1ns/100ps
module lcb_blk_xfer #(
  parameter int BYTES = 5
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic load,
  input wire logic [8*BYTES-1:0] load_data,
  input wire logic [7:0] load_count,
  input wire logic rd_req,
  output logic [8*BYTES-1:0] cap_data,
  output logic [7:0] cap_count,
  output logic [7:0] cap_bytes,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  typedef struct packed {
    logic [8*BYTES-1:0] data;
    logic [7:0] count;
    logic [7:0] got;
    logic seen_count;
    logic [8*BYTES+7:0] shift;
    logic [7:0] rd_data;
    logic rd_valid;
  } lcb_blk_t;

  lcb_blk_t s_r;
  lcb_blk_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    if (clear) begin
      s_nxt.data = '0;
      s_nxt.count = 8'h00;
      s_nxt.got = 8'h00;
      s_nxt.seen_count = 1'b0;
    end else if (wr_valid) begin
      // byte count comes first, data follows low byte first
      if (!s_r.seen_count) begin
        s_nxt.count = wr_data;
        s_nxt.seen_count = 1'b1;
      end else begin
        if (s_r.got < 8'(BYTES)) begin
          s_nxt.data[s_r.got*8 +: 8] = wr_data;
        end
        if (s_r.got != 8'hff) begin
          s_nxt.got = s_r.got + 8'h01;
        end
      end
    end
    if (load) begin
      s_nxt.shift = {load_data, load_count};
    end else if (rd_req) begin
      s_nxt.rd_data = s_r.shift[7:0];
      s_nxt.shift = {8'h00, s_r.shift[8*BYTES+7:8]};
      s_nxt.rd_valid = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cap_data = s_r.data;
  assign cap_count = s_r.count;
  assign cap_bytes = s_r.got;
  assign rd_data = s_r.rd_data;
  assign rd_valid = s_r.rd_valid;
endmodule

/* lcb_properties.sv */
// assertions on the configuration register ports
`timescale 1ns/100ps
module lcb_properties (
  input wire logic clock,
  input wire logic resetn,
  input wire logic txn_stop,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic txn_done,
  input wire logic nack_data,
  input wire logic conv_enable,
  input wire logic restore_all,
  input wire logic analog_supply_input,
  input wire logic [5:0] cur_gain_res_code,
  input wire logic [3:0] bias_voltage_code,
  input wire logic bias_apply
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_ask; rd_req; endsequence
  sequence s_ans; ##1 rd_valid; endsequence
  property p_rd_ans; s_ask |-> s_ans; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read byte late");
  property p_rd_src; rd_valid |-> $past(rd_req); endproperty
  a_rd_src: assert property (p_rd_src)
    else $error("unrequested read byte");
  property p_done; txn_done |-> $past(txn_stop); endproperty
  a_done: assert property (p_done)
    else $error("done without stop");
  property p_nack; nack_data |-> txn_done && !bias_apply; endproperty
  a_nack: assert property (p_nack)
    else $error("rejected write applied");
  property p_bias_chg; $changed(bias_voltage_code) |-> bias_apply; endproperty
  a_bias_chg: assert property (p_bias_chg)
    else $error("bias changed silently");
  property p_bias_ok;
    bias_apply |-> bias_voltage_code inside {[4'h3:4'ha]};
  endproperty
  a_bias_ok: assert property (p_bias_ok)
    else $error("invalid bias applied");
  property p_apply; bias_apply |=> !bias_apply; endproperty
  a_apply: assert property (p_apply)
    else $error("apply pulse too long");
  property p_hold;
    $changed(cur_gain_res_code) && $past(conv_enable) |->
      $past(restore_all) || $past(analog_supply_input, 3);
  endproperty
  a_hold: assert property (p_hold)
    else $error("loop changed while converting");
endmodule
bind lcb_config_regs lcb_properties u_props (.clock, .resetn, .txn_stop,
  .rd_req, .rd_valid, .txn_done, .nack_data, .conv_enable, .restore_all,
  .analog_supply_input, .cur_gain_res_code, .bias_voltage_code,
  .bias_apply);

/* lcb_host_model.sv */
// host model issuing block transactions
`timescale 1ns/100ps
module lcb_host_model (
  input wire logic clock,
  input wire logic [7:0] rd_data,
  output logic txn_start,
  output logic [7:0] txn_cmd,
  output logic txn_read,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req,
  output logic txn_stop
);
  initial begin
    {txn_start, txn_read, wr_valid, rd_req, txn_stop} = 5'h0;
    txn_cmd = 8'h00;
    wr_data = 8'h00;
  end
  task automatic open_txn(input logic [7:0] cmd, input logic rd);
    @(negedge clock);
    txn_start = 1'b1;
    txn_cmd = cmd;
    txn_read = rd;
    @(negedge clock);
    txn_start = 1'b0;
    txn_cmd = ~cmd;
  endtask
  task automatic close_txn();
    @(negedge clock);
    txn_stop = 1'b1;
    @(negedge clock);
    txn_stop = 1'b0;
  endtask
  // count byte first, then data lsb first
  task automatic blk_write(input logic [7:0] cmd, input logic [7:0] cnt,
      input int n, input logic [39:0] d);
    logic [47:0] img;
    img = {d, cnt};
    open_txn(cmd, 1'b0);
    for (int i = 0; i <= n; i++) begin
      wr_valid = 1'b1;
      wr_data = img[8*i +: 8];
      @(negedge clock);
    end
    wr_valid = 1'b0;
    wr_data = ~wr_data;
    close_txn();
  endtask
  task automatic blk_read(input logic [7:0] cmd, input int n,
      output logic [47:0] q);
    q = 48'h0000_0000_0000;
    open_txn(cmd, 1'b1);
    // request held over back-to-back edges, one byte per edge
    rd_req = 1'b1;
    for (int i = 0; i <= n; i++) begin
      @(negedge clock);
      q[8*i +: 8] = rd_data;
    end
    rd_req = 1'b0;
    close_txn();
  endtask
endmodule

/* lcb_config_regs_tb.sv */
// self-checking bench for the configuration registers
`timescale 1ns/100ps
module lcb_config_regs_tb;
  logic clock, resetn, conv_enable, store_all, restore_all;
  logic strap_override_mask, analog_supply_input, txn_start, txn_read;
  logic wr_valid, rd_req, txn_stop, rd_valid, txn_done, nack_data;
  logic nack_cmd, txn_timeout, comp_pending, cur_integ_cap_doubler;
  logic bias_apply;
  logic [7:0] txn_cmd, wr_data, rd_data;
  logic [3:0] cur_integ_cap_code, volt_integ_cap_code, bias_voltage_code;
  logic [4:0] cur_filter_cap_code, volt_filter_cap_code;
  logic [5:0] cur_gain_res_code, volt_gain_res_code;
  logic [1:0] volt_transcond_exp, cur_transcond_exp;
  int n_errors = 0;
  int checked = 0;
  localparam int TXN_CYC = 64;
  int n_rd = 0;
  always @(negedge clock) begin
    if (rd_valid === 1'b1) n_rd++;
  end
  wire [34:0] loop_now = {cur_integ_cap_code, cur_filter_cap_code,
    cur_integ_cap_doubler, cur_gain_res_code, volt_integ_cap_code,
    volt_filter_cap_code, volt_gain_res_code, volt_transcond_exp,
    cur_transcond_exp};
  lcb_host_model host (.clock, .rd_data, .txn_start, .txn_cmd, .txn_read,
    .wr_valid, .wr_data, .rd_req, .txn_stop);
  lcb_config_regs #(.MAX_TXN_CYC(TXN_CYC)) uut (.clock, .resetn, .txn_start,
    .txn_cmd, .txn_read, .wr_valid, .wr_data, .rd_req, .txn_stop,
    .conv_enable, .store_all, .restore_all, .strap_override_mask,
    .analog_supply_input, .rd_data, .rd_valid, .txn_done, .nack_data,
    .nack_cmd, .txn_timeout, .comp_pending, .cur_integ_cap_code,
    .cur_filter_cap_code, .cur_integ_cap_doubler, .cur_gain_res_code,
    .volt_integ_cap_code, .volt_filter_cap_code, .volt_gain_res_code,
    .volt_transcond_exp, .cur_transcond_exp, .bias_voltage_code,
    .bias_apply);
  function automatic logic [34:0] fields(input logic [39:0] w);
    return {w[25:24], w[39:38], w[37:33], w[32], w[31:26], w[9:8],
      w[23:22], w[21:17], w[15:10], w[5:4], w[1:0]};
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
    @(negedge clock);
  endtask
  task automatic t_comp();
    logic [39:0] w1, w2;
    logic [47:0] q;
    w1 = 40'hd6_9bae_c731;
    w2 = 40'h29_6450_3812;
    chk({bias_voltage_code, loop_now},
      {lcb_pkg::BIAS_RST, fields(lcb_pkg::COMP_RST)});
    host.blk_write(lcb_pkg::CMD_COMP, 8'h05, 4, w2);
    chk({txn_done, nack_data, loop_now},
      {2'b11, fields(lcb_pkg::COMP_RST)});
    host.blk_write(lcb_pkg::CMD_COMP, 8'h05, 5, w1);
    chk(loop_now, fields(w1));
    host.blk_read(lcb_pkg::CMD_COMP, 5, q);
    chk(q, {w1, 8'h05});
    chk(n_rd, 6);
    conv_enable = 1'b1;
    host.blk_write(lcb_pkg::CMD_COMP, 8'h05, 5, w2);
    chk({comp_pending, loop_now}, {1'b1, fields(w1)});
    host.blk_read(lcb_pkg::CMD_COMP, 5, q);
    chk(q, {w2, 8'h05});
    pulse(store_all);
    pulse(restore_all);
    chk(loop_now, fields(w1));
    strap_override_mask = 1'b0;
    pulse(restore_all);
    chk({comp_pending, loop_now}, {1'b0, fields(w2)});
    // stored word reaches the loop through a supply cycle
    host.blk_write(lcb_pkg::CMD_COMP, 8'h05, 5, w1);
    pulse(store_all);
    analog_supply_input = 1'b1;
    repeat (4) @(negedge clock);
    chk({comp_pending, loop_now}, {1'b0, fields(w1)});
  endtask
  task automatic t_bias();
    logic [3:0] cur;
    logic [47:0] q;
    cur = bias_voltage_code;
    // codes 2h and Bh just outside the range are rejected, run ends on Bh
    for (int c = 2; c <= 11; c++) begin
      host.blk_write(lcb_pkg::CMD_BIAS, 8'h01, 1, {32'h0, c[3:0], 4'hf});
      if (c >= 3 && c <= 10) cur = c[3:0];
      chk({nack_data, bias_apply, bias_voltage_code},
        {c < 3 || c > 10, c >= 3 && c <= 10, cur});
      host.blk_read(lcb_pkg::CMD_BIAS, 1, q);
      chk(q, {32'h0, cur, 4'h0, 8'h01});
    end
    host.blk_write(lcb_pkg::CMD_BIAS, 8'h01, 2, 40'h00_0000_5050);
    chk({nack_data, bias_voltage_code}, {1'b1, cur});
  endtask
  task automatic t_abort();
    int k;
    host.open_txn(8'hb2, 1'b0);
    chk(nack_cmd, 1'b1);
    k = 0;
    host.open_txn(lcb_pkg::CMD_BIAS, 1'b0);
    while (txn_timeout !== 1'b1 && k < 90) begin
      @(negedge clock);
      k++;
    end
    chk(k, TXN_CYC);
  endtask
  task automatic stop_test();
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #50000;
    n_errors++;
    stop_test();
  end
  initial begin
    resetn = 1'b0;
    {conv_enable, store_all, restore_all, analog_supply_input} = 4'h0;
    strap_override_mask = 1'b1;
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    t_comp();
    t_bias();
    t_abort();
    stop_test();
  end
endmodule
